// [src/smp_ahb_ports.sv]
// Bus front end of a static memory controller: AHB slave port and test master port.
// Assumes an external decoder drives both selects and an arbiter drives the grant.
//
// Notes on behaviour
// - The inverted clock only forms the memory write enable.
// - All bus signals are sampled and launched on the rising clock edge.
// - Logic resets while the bus reset input is low.
// - A transfer is finished only when the ready input is high.
// - The slave port takes only the low 29 address bits.
// - The slave port decodes idle, busy, nonsequential and sequential types.
// - The slave port handles byte, halfword and word sizes for memory; register accesses narrower than a word get ERROR.
// - Incrementing and wrapping bursts of four, eight and sixteen beats work.
// - Write high means write into the device, low means read.
// - Only memory-selected transfers reach the memory banks.
// - Register accesses are served only under the register select.
// - Ready out high completes a transfer, low inserts wait states.
// - The slave answers only OKAY or ERROR.
// - Write and read data buses are 32 bits wide.
// - The test master handles SPLIT and RETRY besides OKAY and ERROR.
// - The test master takes the bus only when ready and grant are high.
// - The test master drives a full 32-bit address.
// - The test master never issues the busy type.
// - The test master issues no size wider than a word.
// - The test master always signals incrementing bursts of unspecified length.
// - The test master drives protection bits for fetch, privilege and caching.
// - The test master requests the bus and waits for grant.
`timescale 1ns/1ps
module smp_ahb_ports (
	input wire logic clk_sys_i,
	input wire logic inverted_bus_clock_i,
	input wire logic rst_b_i,
	input wire logic hreadyin_i,
	input wire logic [28:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [2:0] hburst_i,
	input wire logic [31:0] hwdata_i,
	input wire logic memory_bank_select_i,
	input wire logic register_select_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic [1:0] hresp_o,
	output logic mem_write_en_b_o,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [31:0] cmd_addr_i,
	input wire logic cmd_write_i,
	input wire logic [2:0] cmd_size_i,
	input wire logic [31:0] cmd_wdata_i,
	input wire logic [3:0] cmd_prot_i,
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	output logic [31:0] rsp_data_o,
	input wire logic [1:0] test_master_response_in_i,
	input wire logic [31:0] test_master_read_data_i,
	input wire logic test_master_grant_i,
	output logic [31:0] test_master_address_o,
	output logic [1:0] test_master_trans_type_o,
	output logic test_master_write_o,
	output logic [2:0] test_master_size_o,
	output logic [2:0] test_master_burst_o,
	output logic [3:0] test_master_protection_o,
	output logic [31:0] test_master_write_data_o,
	output logic test_master_bus_request_o
);
	logic rst_meta;
	logic rst_b;
	logic [31:0] mem_array [smp_pkg::MEM_WORDS];
	logic [31:0] bank_control_regs [smp_pkg::REG_WORDS];
	logic dp_valid;
	logic dp_write;
	logic dp_mem;
	logic dp_err;
	logic [28:0] dp_addr;
	logic [2:0] dp_size;
	logic [7:0] wait_cnt;
	logic addr_take;
	logic active;
	logic mem_we_pend;
	logic wr_now;
	logic [3:0] lane_en;
	logic [31:0] merged;
	logic [5:0] mem_idx;
	logic [2:0] reg_idx;
	smp_pkg::smp_mst_e mst_state;
	logic q_valid;
	logic q_ready;
	logic [31:0] q_addr;
	logic q_write;
	logic [2:0] q_size;
	logic [31:0] q_wdata;
	logic [3:0] q_prot;
	logic [71:0] q_bundle;
	logic [1:0] retry_trans;
	logic rsp_in_valid;
	logic rsp_in_ready;
	logic [31:0] rsp_in_data;
	logic rsp_busy;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_meta <= 1'b0;
			rst_b <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_b <= rst_meta;
		end
	end

	// Nonsequential and sequential beats move data; idle and busy are answered with zero wait.
	assign active = htrans_i[1];
	assign addr_take = hreadyin_i && active && (memory_bank_select_i || register_select_i);
	assign mem_idx = dp_addr[7:2];
	assign reg_idx = dp_addr[4:2];

	always_comb
	begin
		lane_en = 4'h0;
		case (dp_size)
			smp_pkg::SIZE_BYTE: lane_en = 4'h1 << dp_addr[1:0];
			smp_pkg::SIZE_HALF: lane_en = dp_addr[1] ? 4'hc : 4'h3;
			default: lane_en = 4'hf;
		endcase
	end

	always_comb
	begin
		merged = dp_mem ? mem_array[mem_idx] : bank_control_regs[reg_idx];
		for (int b = 0; b < 4; b++)
			if (lane_en[b])
				merged[8*b +: 8] = hwdata_i[8*b +: 8];
	end

	// Address phase capture; each burst beat is taken at the address the master drives, and hburst_i is ignored.
	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_mem <= 1'b0;
			dp_err <= 1'b0;
			dp_addr <= '0;
			dp_size <= smp_pkg::SIZE_BYTE;
		end
		else if (hreadyout_o && hreadyin_i)
		begin
			dp_valid <= addr_take;
			dp_write <= hwrite_i;
			dp_mem <= memory_bank_select_i;
			dp_err <= register_select_i && !memory_bank_select_i && hsize_i != smp_pkg::SIZE_WORD;
			dp_addr <= haddr_i;
			dp_size <= hsize_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			wait_cnt <= 8'h00;
		else if (hreadyout_o && hreadyin_i && addr_take && memory_bank_select_i)
			wait_cnt <= smp_pkg::MEM_WAIT_CYCLES;
		else if (wait_cnt != 8'h00)
			wait_cnt <= wait_cnt - 8'h01;
	end

	assign hreadyout_o = (wait_cnt == 8'h00);

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			hresp_o <= smp_pkg::RESP_OKAY;
		else if (hreadyout_o && hreadyin_i)
			hresp_o <= (hreadyin_i && addr_take && register_select_i && !memory_bank_select_i
				&& hsize_i != smp_pkg::SIZE_WORD) ? smp_pkg::RESP_ERROR : smp_pkg::RESP_OKAY;
	end

	assign wr_now = dp_valid && dp_write && hreadyout_o && hreadyin_i && !dp_err;

	always_ff @(posedge clk_sys_i)
	begin
		if (wr_now)
		begin
			if (dp_mem)
				mem_array[mem_idx] <= merged;
			else
				bank_control_regs[reg_idx] <= merged;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			hrdata_o <= smp_pkg::ZERO_WORD;
		else if (hreadyout_o && hreadyin_i && addr_take && !hwrite_i)
		begin
			// A write completing in the same cycle is forwarded so the read sees it.
			if (wr_now && dp_mem == memory_bank_select_i
				&& (memory_bank_select_i ? (mem_idx == haddr_i[7:2]) : (reg_idx == haddr_i[4:2])))
				hrdata_o <= merged;
			else
				hrdata_o <= memory_bank_select_i ? mem_array[haddr_i[7:2]] : bank_control_regs[haddr_i[4:2]];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
			mem_we_pend <= 1'b0;
		else
			mem_we_pend <= wr_now && dp_mem;
	end

	// Write strobe is shaped on the falling edge, half a cycle after the write's data phase completes.
	always_ff @(posedge inverted_bus_clock_i or negedge rst_b)
	begin
		if (!rst_b)
			mem_write_en_b_o <= 1'b1;
		else
			mem_write_en_b_o <= !mem_we_pend;
	end

	assign q_bundle = {cmd_addr_i, cmd_write_i, cmd_size_i, cmd_prot_i, cmd_wdata_i};

	smp_fifo #(
		.WIDTH(72),
		.DEPTH(smp_pkg::FIFO_DEPTH)
	) u_cmd_fifo (
		.clk_i(clk_sys_i),
		.rst_b_i(rst_b),
		.in_valid_i(cmd_valid_i),
		.in_ready_o(cmd_ready_o),
		.in_data_i(q_bundle),
		.out_valid_o(q_valid),
		.out_ready_i(q_ready),
		.out_data_o({q_addr, q_write, q_size, q_prot, q_wdata})
	);

	assign q_ready = (mst_state == smp_pkg::SMP_M_ADDR) && hreadyin_i && test_master_grant_i
		&& (retry_trans == smp_pkg::TRANS_IDLE);

	// Test master: one transfer per command, retried on SPLIT or RETRY.
	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mst_state <= smp_pkg::SMP_M_IDLE;
			test_master_bus_request_o <= 1'b0;
			test_master_address_o <= smp_pkg::ZERO_WORD;
			test_master_trans_type_o <= smp_pkg::TRANS_IDLE;
			test_master_write_o <= 1'b0;
			test_master_size_o <= smp_pkg::SIZE_BYTE;
			test_master_protection_o <= smp_pkg::PROT_RESET;
			test_master_write_data_o <= smp_pkg::ZERO_WORD;
			retry_trans <= smp_pkg::TRANS_IDLE;
			rsp_in_valid <= 1'b0;
			rsp_in_data <= smp_pkg::ZERO_WORD;
		end
		else
		begin
			rsp_in_valid <= 1'b0;
			case (mst_state)
				smp_pkg::SMP_M_IDLE:
				begin
					test_master_trans_type_o <= smp_pkg::TRANS_IDLE;
					if (q_valid && rsp_in_ready)
					begin
						test_master_bus_request_o <= 1'b1;
						mst_state <= smp_pkg::SMP_M_REQ;
					end
				end
				smp_pkg::SMP_M_REQ:
					mst_state <= smp_pkg::SMP_M_ADDR;
				smp_pkg::SMP_M_ADDR:
				begin
					if (hreadyin_i && test_master_grant_i)
					begin
						// A retried transfer reissues the held address and control.
						if (retry_trans == smp_pkg::TRANS_IDLE)
						begin
							test_master_address_o <= q_addr;
							test_master_write_o <= q_write;
							test_master_size_o <= (q_size > smp_pkg::SIZE_WORD) ? smp_pkg::SIZE_WORD : q_size;
							test_master_protection_o <= q_prot;
							test_master_write_data_o <= q_wdata;
						end
						retry_trans <= smp_pkg::TRANS_IDLE;
						test_master_trans_type_o <= smp_pkg::TRANS_NONSEQ;
						mst_state <= smp_pkg::SMP_M_DATA;
					end
				end
				smp_pkg::SMP_M_DATA:
				begin
					if (test_master_trans_type_o != smp_pkg::TRANS_IDLE && hreadyin_i)
						test_master_trans_type_o <= smp_pkg::TRANS_IDLE;
					if (test_master_trans_type_o == smp_pkg::TRANS_IDLE && hreadyin_i)
					begin
						if (test_master_response_in_i == smp_pkg::RESP_SPLIT
							|| test_master_response_in_i == smp_pkg::RESP_RETRY)
						begin
							retry_trans <= smp_pkg::TRANS_NONSEQ;
							mst_state <= smp_pkg::SMP_M_REQ;
						end
						else
						begin
							rsp_in_valid <= 1'b1;
							rsp_in_data <= test_master_read_data_i;
							test_master_bus_request_o <= 1'b0;
							mst_state <= smp_pkg::SMP_M_IDLE;
						end
					end
				end
				default: mst_state <= smp_pkg::SMP_M_IDLE;
			endcase
		end
	end

	assign test_master_burst_o = smp_pkg::BURST_INCR;
	// A command starts only when the result slot is empty, so no result is overwritten.
	assign rsp_busy = rsp_valid_o || rsp_in_valid;
	assign rsp_in_ready = !rsp_busy;

	always_ff @(posedge clk_sys_i or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rsp_valid_o <= 1'b0;
			rsp_data_o <= smp_pkg::ZERO_WORD;
		end
		else if (rsp_in_valid)
		begin
			rsp_valid_o <= 1'b1;
			rsp_data_o <= rsp_in_data;
		end
		else if (rsp_ready_i)
			rsp_valid_o <= 1'b0;
	end

	property p_unsel_okay;
		@(posedge clk_sys_i) disable iff (!rst_b)
		(hreadyin_i && hreadyout_o && !memory_bank_select_i && !register_select_i) |=> (hresp_o == smp_pkg::RESP_OKAY);
	endproperty
	a_unsel_okay: assert property (p_unsel_okay) else $error("Unselected transfer not OKAY.");

	property p_resp_legal;
		@(posedge clk_sys_i) disable iff (!rst_b)
		hresp_o == smp_pkg::RESP_OKAY || hresp_o == smp_pkg::RESP_ERROR;
	endproperty
	a_resp_legal: assert property (p_resp_legal) else $error("Slave response not OKAY or ERROR.");

	property p_mem_wait;
		@(posedge clk_sys_i) disable iff (!rst_b)
		(hreadyin_i && hreadyout_o && addr_take && memory_bank_select_i) |=> !hreadyout_o ##1 hreadyout_o;
	endproperty
	a_mem_wait: assert property (p_mem_wait) else $error("Memory wait state wrong.");

	property p_no_busy;
		@(posedge clk_sys_i) disable iff (!rst_b)
		test_master_trans_type_o != smp_pkg::TRANS_BUSY;
	endproperty
	a_no_busy: assert property (p_no_busy) else $error("Test master issued busy.");

	property p_size_max;
		@(posedge clk_sys_i) disable iff (!rst_b)
		test_master_size_o <= smp_pkg::SIZE_WORD;
	endproperty
	a_size_max: assert property (p_size_max) else $error("Test master size too wide.");

	property p_burst_incr;
		@(posedge clk_sys_i) disable iff (!rst_b)
		test_master_burst_o == smp_pkg::BURST_INCR;
	endproperty
	a_burst_incr: assert property (p_burst_incr) else $error("Test master burst not incrementing.");

	sequence s_new_addr;
		$rose(test_master_trans_type_o == smp_pkg::TRANS_NONSEQ);
	endsequence
	property p_take_on_grant;
		@(posedge clk_sys_i) disable iff (!rst_b)
		s_new_addr |-> $past(hreadyin_i) && $past(test_master_grant_i) && $past(test_master_bus_request_o);
	endproperty
	a_take_on_grant: assert property (p_take_on_grant) else $error("Bus taken without grant.");

	property p_reg_size_err;
		@(posedge clk_sys_i) disable iff (!rst_b)
		(hreadyin_i && hreadyout_o && active && register_select_i && !memory_bank_select_i
			&& hsize_i != smp_pkg::SIZE_WORD) |=> hresp_o == smp_pkg::RESP_ERROR;
	endproperty
	a_reg_size_err: assert property (p_reg_size_err) else $error("Narrow register access not refused.");
endmodule

// [src/smp_pkg.sv]
// Package of constants shared by the static memory controller bus front end.
// Assumes an AHB system bus with 32-bit data and a 250 MHz system clock.
package smp_pkg;
	localparam int SLV_ADDR_W = 29;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 32;
	localparam int MEM_WORDS = 64;
	localparam int REG_WORDS = 8;
	localparam logic [1:0] TRANS_IDLE = 2'h0;
	localparam logic [1:0] TRANS_BUSY = 2'h1;
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;
	localparam logic [1:0] TRANS_SEQ = 2'h3;
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic [2:0] BURST_INCR = 3'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_ERROR = 2'h1;
	localparam logic [1:0] RESP_RETRY = 2'h2;
	localparam logic [1:0] RESP_SPLIT = 2'h3;
	localparam logic [3:0] PROT_DEFAULT = 4'h1;
	localparam logic [3:0] PROT_RESET = 4'h0;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [7:0] MEM_WAIT_CYCLES = 8'h01;
	typedef enum logic [1:0] {
		SMP_M_IDLE = 2'b00,
		SMP_M_REQ = 2'b01,
		SMP_M_ADDR = 2'b11,
		SMP_M_DATA = 2'b10
	} smp_mst_e;
endpackage

// [src/smp_fifo.sv]
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronised active-low reset.
`timescale 1ns/1ps
module smp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready_o = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// [verification/smp_far_slave.sv]
// Far side of the test master: a bus arbiter and one slave of 16 words.
// Assumes the test master holds address and control while the ready input is low.
`timescale 1ns/1ps
module smp_far_slave (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ready_i,
	input wire logic hold_i,
	input wire logic [1:0] fault_i,
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic [1:0] trans_i,
	input wire logic write_i,
	input wire logic [31:0] wdata_i,
	output logic grant_o,
	output logic [1:0] resp_o,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [16];
	logic [31:0] last;
	logic [3:0] idx;
	logic ph;
	logic wr;
	logic used;
	// Grant follows the request a cycle later unless the bench withholds it.
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			grant_o <= 1'b0;
		else
			grant_o <= req_i & !hold_i;
	// A data phase follows a granted nonsequential address phase.
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			ph <= 1'b0;
			used <= 1'b0;
			last <= 32'h0000_0000;
		end
		else
		begin
			last <= rdata_o;
			if (ready_i)
			begin
				ph <= grant_o & trans_i == smp_pkg::TRANS_NONSEQ;
				wr <= write_i;
				idx <= addr_i[5:2];
				if (ph & wr & resp_o == smp_pkg::RESP_OKAY)
					mem[idx] <= wdata_i;
				if (ph)
					used <= fault_i != smp_pkg::RESP_OKAY;
			end
		end
	// One odd response is given per armed fault, then the retry succeeds.
	assign resp_o = ph & !used ? fault_i : smp_pkg::RESP_OKAY;
	// Outside a read data phase the bus shows a pattern that changes every cycle.
	assign rdata_o = ph & !wr ? mem[idx] : ~last;
endmodule

// [verification/static_mem_ctrl_ahb_ports_tb.sv]
// Testbench of the bus front end: slave port traffic and test master commands.
// Assumes the far side model smp_far_slave and a 250 MHz clock.
`timescale 1ns/1ps
module static_mem_ctrl_ahb_ports_tb;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic stall = 1'b0, sten = 1'b0, hold = 1'b1, hwrite = 1'b0, msel = 1'b0, rsel = 1'b0;
	logic cvalid = 1'b0, cwr = 1'b0, rrdy = 1'b0;
	logic [1:0] htrans = 2'h0, fault = 2'h0;
	logic [2:0] hsize = 3'h0, hburst = 3'h0, csize = 3'h0, hb;
	logic [28:0] haddr = 29'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000, caddr = 32'h0000_0000, cwdata = 32'h0000_0000;
	logic [3:0] cprot = 4'h0;
	wire hready, hrdyo, mwe_b, cready, rvalid, grant, breq, twr;
	wire [1:0] hresp, tresp, ttrans;
	wire [2:0] tsize, tburst;
	wire [3:0] tprot;
	wire [31:0] hrdata, rdata, trdata, taddr, twdata;
	int errors = 0, checked = 0, wen = 0, ew = 0;
	logic [31:0] mm [64], rm [8], tm [16];
	logic [32:0] eq [$];
	// Another slave may stretch the transfer by pulling ready low.
	assign hready = hrdyo & !stall;
	initial
		forever #2 clk_sys_i = ~clk_sys_i;
	smp_ahb_ports uut (.clk_sys_i(clk_sys_i), .inverted_bus_clock_i(~clk_sys_i), .rst_b_i(rst_b_i),
		.hreadyin_i(hready), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hburst_i(hburst), .hwdata_i(hwdata), .memory_bank_select_i(msel), .register_select_i(rsel),
		.hrdata_o(hrdata), .hreadyout_o(hrdyo), .hresp_o(hresp), .mem_write_en_b_o(mwe_b),
		.cmd_valid_i(cvalid), .cmd_ready_o(cready), .cmd_addr_i(caddr), .cmd_write_i(cwr),
		.cmd_size_i(csize), .cmd_wdata_i(cwdata), .cmd_prot_i(cprot), .rsp_valid_o(rvalid),
		.rsp_ready_i(rrdy), .rsp_data_o(rdata), .test_master_response_in_i(tresp),
		.test_master_read_data_i(trdata), .test_master_grant_i(grant), .test_master_address_o(taddr),
		.test_master_trans_type_o(ttrans), .test_master_write_o(twr), .test_master_size_o(tsize),
		.test_master_burst_o(tburst), .test_master_protection_o(tprot),
		.test_master_write_data_o(twdata), .test_master_bus_request_o(breq));
	smp_far_slave far (.clk_i(clk_sys_i), .rst_b_i(rst_b_i), .ready_i(hready), .hold_i(hold),
		.fault_i(fault), .req_i(breq), .addr_i(taddr), .trans_i(ttrans), .write_i(twr),
		.wdata_i(twdata), .grant_o(grant), .resp_o(tresp), .rdata_o(trdata));
	task automatic finish_test();
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop();
		errors++;
		finish_test();
	endtask
	task automatic tick(output int n);
		n = 0;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		if (n >= 64)
			stop();
	endtask
	// One slave transfer: address phase, then a data phase carrying trans type dtr.
	task automatic xfer(input logic [1:0] sel, input logic wr, input logic [2:0] sz, input logic [28:0] a,
		input logic [1:0] tr, input logic [1:0] dtr);
		logic [31:0] d;
		logic act;
		int w;
		d = $urandom;
		act = tr[1] & sel != 2'b00;
		msel <= sel[0];
		rsel <= sel[1];
		hwrite <= wr;
		hsize <= sz;
		haddr <= a;
		htrans <= tr;
		hburst <= hb;
		tick(w);
		htrans <= dtr;
		hwdata <= d;
		tick(w);
		chk("hresp", sel == 2'b10 & act & sz != smp_pkg::SIZE_WORD, hresp);
		if (!sten)
			chk("waits", sel == 2'b01 & act ? 2 : 1, w);
		if (act & !wr & sz == smp_pkg::SIZE_WORD)
			chk("hrdata", sel[0] ? mm[a[7:2]] : rm[a[4:2]], hrdata);
		if (act & wr & sel == 2'b01)
		begin
			ew++;
			for (int i = 0; i < 4; i++)
				if (sz == 3'h2 || (sz == 3'h1 && i[1] == a[1]) || (sz == 3'h0 && i[1:0] == a[1:0]))
					mm[a[7:2]][i*8 +: 8] = d[i*8 +: 8];
		end
		if (act & wr & sel == 2'b10 & sz == smp_pkg::SIZE_WORD)
			rm[a[4:2]] = d;
	endtask
	task automatic tcmd(input logic wr, input logic [3:0] i, input logic [2:0] sz, input int lim,
		output logic acc);
		logic [31:0] a;
		logic [31:0] d;
		int n;
		a = {4'ha, 22'($urandom), i, 2'b00};
		d = $urandom;
		n = 0;
		@(posedge clk_sys_i);
		cvalid <= 1'b1;
		caddr <= a;
		cwr <= wr;
		csize <= sz;
		cwdata <= d;
		cprot <= a[9:6];
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (cready !== 1'b1 && n < lim);
		acc = cready === 1'b1;
		cvalid <= 1'b0;
		if (!acc && lim > 8)
			stop();
		if (acc && wr)
			tm[i] = d;
		if (acc)
			eq.push_back({!wr & sz >= 3'h2, tm[i]});
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (eq.size() != 0 && n < 4000)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		if (eq.size() != 0)
			stop();
	endtask
	// Results are taken with a stalling consumer and compared in order.
	always @(posedge clk_sys_i)
	begin
		logic [32:0] e;
		rrdy <= 1'($urandom % 2);
		stall <= sten & ($urandom % 3 == 0);
		if (rvalid === 1'b1 && rrdy === 1'b1)
		begin
			chk("rsp_count", 1, eq.size() != 0);
			e = eq.pop_front();
			if (e[32])
				chk("rsp_data", e[31:0], rdata);
		end
	end
	always @(posedge clk_sys_i)
		if (rst_b_i)
		begin
			chk("burst", smp_pkg::BURST_INCR, tburst);
			chk("busy", 1, ttrans != smp_pkg::TRANS_BUSY);
			chk("size", 1, tsize <= smp_pkg::SIZE_WORD);
			if (ttrans === smp_pkg::TRANS_NONSEQ && hready === 1'b1)
			begin
				chk("grant", 1, grant);
				chk("addr", 4'ha, taddr[31:28]);
				chk("prot", taddr[9:6], tprot);
			end
		end
	always @(negedge mwe_b)
		wen++;
	initial
	begin
		logic [28:0] a;
		logic [2:0] sz;
		logic [1:0] o;
		logic acc;
		int cnt;
		void'($urandom(32'h02fc));
		repeat (16) @(posedge clk_sys_i);
		chk("rst ready", 1, hrdyo);
		chk("rst resp", smp_pkg::RESP_OKAY, hresp);
		chk("rst req", 0, breq);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		wen = 0;
		hold <= 1'b0;
		fork
			for (int k = 0; k < 16; k++)
			begin
				sten = k >= 8;
				hb = 3'(2 + k % 6);
				a = 29'($urandom) & 29'h1fff_fffc;
				sz = 3'(k % 2);
				o = sz[0] ? {k[1], 1'b0} : 2'(k);
				xfer(2'b10, 1, smp_pkg::SIZE_WORD, a, smp_pkg::TRANS_NONSEQ, smp_pkg::TRANS_IDLE);
				xfer(2'b01, 1, smp_pkg::SIZE_WORD, a, smp_pkg::TRANS_NONSEQ, smp_pkg::TRANS_IDLE);
				xfer(2'b01, 1, sz, {a[28:2], o}, smp_pkg::TRANS_SEQ, smp_pkg::TRANS_BUSY);
				xfer(2'b01, 1, smp_pkg::SIZE_WORD, a, 2'(k % 2), smp_pkg::TRANS_IDLE);
				xfer(2'b00, 1, smp_pkg::SIZE_WORD, a, smp_pkg::TRANS_NONSEQ, smp_pkg::TRANS_IDLE);
				xfer(2'b10, 1, 3'(k % 3), a, smp_pkg::TRANS_SEQ, smp_pkg::TRANS_IDLE);
				xfer(2'b01, 0, smp_pkg::SIZE_WORD, a, smp_pkg::TRANS_NONSEQ, smp_pkg::TRANS_IDLE);
				xfer(2'b10, 0, smp_pkg::SIZE_WORD, a, smp_pkg::TRANS_NONSEQ, smp_pkg::TRANS_IDLE);
			end
			begin
				for (int i = 0; i < 32; i++)
					tcmd(i < 16, 4'(i), 3'($urandom % 8), 16, acc);
				drain();
				hold <= 1'b1;
				cnt = 0;
				acc = 1'b1;
				while (acc && cnt < 40)
				begin
					tcmd(0, 4'($urandom), smp_pkg::SIZE_WORD, 8, acc);
					cnt += acc;
				end
				chk("fill", 1, cnt == smp_pkg::FIFO_DEPTH || cnt == smp_pkg::FIFO_DEPTH + 1);
				hold <= 1'b0;
				drain();
				for (int f = 2; f < 4; f++)
				begin
					fault <= 2'(f);
					tcmd(0, 4'(f), smp_pkg::SIZE_WORD, 16, acc);
					drain();
					fault <= smp_pkg::RESP_OKAY;
					tcmd(0, 4'(f + 4), smp_pkg::SIZE_WORD, 16, acc);
					drain();
				end
			end
		join
		repeat (8) @(posedge clk_sys_i);
		chk("wen", ew, wen);
		finish_test();
	end
endmodule
